// File: rtl/bbreg_map.vh
// register map and field layout of the second buck regulator configuration bank
`ifndef BBREG_MAP_VH
`define BBREG_MAP_VH
`define BBREG_ADDR_NORMAL   8'h35
`define BBREG_ADDR_STANDBY  8'h36
`define BBREG_ADDR_SLEEP    8'h37
`define BBREG_ADDR_MODE     8'h38
`define BBREG_ADDR_CONFIG   8'h39
`define BBREG_CODE_MSB      5
`define BBREG_RANGE_BIT     6
`define BBREG_MODE_MSB      3
`define BBREG_SLEEP_BIT     5
`define BBREG_ILIM_BIT      0
`define BBREG_SPARE_BIT     1
`define BBREG_FREQ_MSB      3
`define BBREG_FREQ_LSB      2
`define BBREG_PHASE_MSB     5
`define BBREG_PHASE_LSB     4
`define BBREG_SLEW_MSB      7
`define BBREG_SLEW_LSB      6
`define BBREG_CODE_RST      6'h00
`define BBREG_MODE_RST      4'h0
`define BBREG_CONF_RST      8'h00
`define BBREG_RESERVED_MIN  7'h73
`define BBREG_ZERO8         8'h00
`define BBREG_CODE7_RST     7'h00
`define BBREG_SEL2_RST      2'h0
`define BBREG_BIT_CLR       1'h0
`define BBREG_BIT_SET       1'h1
`define BBREG_PAD1          1'h0
`define BBREG_PAD2          2'h0
`define BBREG_NUM_CODES     3
`define BBREG_IDX_NORMAL    0
`define BBREG_IDX_STANDBY   1
`define BBREG_IDX_SLEEP     2
`endif

// File: rtl/bbreg_bank.v
// configuration register bank of the second buck regulator
`timescale 1ns/1ps
// What this block does
// - 7-bit voltage code, top bit range; codes 1110011 and above reserved.
// - normal voltage bits 5:0 read-write, reset zero, drive normal output.
// - normal range bit 6 read-only, set only by programmed configuration.
// - standby voltage bits 5:0 read-write, used in Standby mode.
// - standby and sleep bit 6 read-only, copy the configured range bit.
// - sleep voltage bits 5:0 read-write, used in Sleep mode.
// - mode register bits 3:0 read-write select switching mode.
// - mode bit 5 picks Sleep state: 0 off, 1 pulse-frequency mode.
// - config bit 0 current limit: 0 high, 1 low; resets zero.
// - config bits 3:2 read-write switching frequency, reset zero.
// - config bits 5:4 read-write switching clock phase.
// - config bits 7:6 read-write voltage slew speed.
// - five registers sit at addresses 0x35 through 0x39.
module bbreg_bank (
  input  wire       i_ref_clk,
  input  wire       i_reset,
  input  wire [7:0] i_reg_addr,
  input  wire [7:0] i_reg_wdata,
  input  wire       i_reg_wr,
  input  wire       i_reg_rd,
  input  wire       i_range_cfg,
  input  wire       i_range_load,
  input  wire       i_standby,
  input  wire       i_sleep,
  output reg  [7:0] o_reg_rdata,
  output reg        o_reg_hit,
  output reg  [6:0] o_active_code,
  output reg        o_code_reserved,
  output reg        o_regulator_on,
  output reg        o_sleep_pfm,
  output reg  [3:0] o_switching_mode,
  output reg        o_current_limit_sel,
  output reg  [1:0] o_frequency_sel,
  output reg  [1:0] o_phase_sel,
  output reg  [1:0] o_slew_speed_sel
);

`include "bbreg_map.vh"

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  // the three set-point registers share one layout and sit side by side
  localparam [23:0] CODE_SLOT_ADDRS = {`BBREG_ADDR_SLEEP,
                                       `BBREG_ADDR_STANDBY,
                                       `BBREG_ADDR_NORMAL};

  wire [2:0] sel_code;
  wire [2:0] wr_code;
  wire       sel_mode;
  wire       sel_config;
  wire       sel_any;
  wire       wr_mode;
  wire       wr_config;

  assign sel_mode   = (i_reg_addr == `BBREG_ADDR_MODE);
  assign sel_config = (i_reg_addr == `BBREG_ADDR_CONFIG);
  assign sel_any    = (|sel_code) | sel_mode | sel_config;
  assign wr_mode    = i_reg_wr & sel_mode;
  assign wr_config  = i_reg_wr & sel_config;

  ////////////////////////////////////////////////////////////////////////////
  // voltage set points, one entry per operating mode
  // write data bits 7:6 fall away, so the host never reaches the range bit
  genvar g;
  generate
    for (g = 0; g < `BBREG_NUM_CODES; g = g + 1) begin : g_code
      reg [5:0] code_q;

      assign sel_code[g] = (i_reg_addr == CODE_SLOT_ADDRS[g*8 +: 8]);
      assign wr_code[g]  = i_reg_wr & sel_code[g];

      always @(posedge i_ref_clk) begin
        if (i_reset) begin
          code_q <= `BBREG_CODE_RST;
        end else if (wr_code[g]) begin
          code_q <= i_reg_wdata[`BBREG_CODE_MSB:0];
        end
      end
    end
  endgenerate

  wire [5:0] buck_b_normal_code;
  wire [5:0] standby_code;
  wire [5:0] sleep_code;

  assign buck_b_normal_code = g_code[`BBREG_IDX_NORMAL].code_q;
  assign standby_code       = g_code[`BBREG_IDX_STANDBY].code_q;
  assign sleep_code         = g_code[`BBREG_IDX_SLEEP].code_q;

  ////////////////////////////////////////////////////////////////////////////
  // range bit
  // loaded only by programmed configuration and kept across a host reset,
  // so it stays unknown until the first load
  reg        range_sel;

  always @(posedge i_ref_clk) begin
    if (i_range_load) begin
      range_sel <= i_range_cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // switching mode register
  reg  [3:0] buck_b_switching_mode;
  reg        buck_b_sleep_state;

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      buck_b_switching_mode <= `BBREG_MODE_RST;
    end else if (wr_mode) begin
      buck_b_switching_mode <= i_reg_wdata[`BBREG_MODE_MSB:0];
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      buck_b_sleep_state <= `BBREG_BIT_CLR;
    end else if (wr_mode) begin
      buck_b_sleep_state <= i_reg_wdata[`BBREG_SLEEP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration register, one flip-flop group per field
  reg        buck_b_current_limit_sel;
  reg        config_spare;
  reg  [1:0] buck_b_frequency_sel;
  reg  [1:0] buck_b_phase_sel;
  reg  [1:0] buck_b_slew_speed_sel;
  wire [7:0] buck_b_config;

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      buck_b_current_limit_sel <= `BBREG_BIT_CLR;
    end else if (wr_config) begin
      buck_b_current_limit_sel <= i_reg_wdata[`BBREG_ILIM_BIT];
    end
  end

  // bit 1 drives nothing but stays read-write, as the host may expect
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      config_spare <= `BBREG_BIT_CLR;
    end else if (wr_config) begin
      config_spare <= i_reg_wdata[`BBREG_SPARE_BIT];
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      buck_b_frequency_sel <= `BBREG_SEL2_RST;
    end else if (wr_config) begin
      buck_b_frequency_sel <= i_reg_wdata[`BBREG_FREQ_MSB:`BBREG_FREQ_LSB];
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      buck_b_phase_sel <= `BBREG_SEL2_RST;
    end else if (wr_config) begin
      buck_b_phase_sel <= i_reg_wdata[`BBREG_PHASE_MSB:`BBREG_PHASE_LSB];
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      buck_b_slew_speed_sel <= `BBREG_SEL2_RST;
    end else if (wr_config) begin
      buck_b_slew_speed_sel <= i_reg_wdata[`BBREG_SLEW_MSB:`BBREG_SLEW_LSB];
    end
  end

  assign buck_b_config = {buck_b_slew_speed_sel, buck_b_phase_sel, buck_b_frequency_sel,
                          config_spare, buck_b_current_limit_sel};

  ////////////////////////////////////////////////////////////////////////////
  // read side
  wire [7:0] normal_view;
  wire [7:0] standby_view;
  wire [7:0] sleep_view;
  wire [7:0] mode_view;
  wire [7:0] config_view;
  reg  [7:0] next_rdata;
  reg        next_hit;

  // unused bits are tied low rather than stored, so writes to them vanish
  assign normal_view  = {`BBREG_PAD1, range_sel, buck_b_normal_code};
  assign standby_view = {`BBREG_PAD1, range_sel, standby_code};
  assign sleep_view   = {`BBREG_PAD1, range_sel, sleep_code};
  assign mode_view    = {`BBREG_PAD2, buck_b_sleep_state, `BBREG_PAD1,
                         buck_b_switching_mode};
  assign config_view  = buck_b_config;

  always @* begin
    next_rdata = `BBREG_ZERO8;
    next_hit   = sel_any;
    case (i_reg_addr)
      `BBREG_ADDR_NORMAL: begin
        next_rdata = normal_view;
      end
      `BBREG_ADDR_STANDBY: begin
        next_rdata = standby_view;
      end
      `BBREG_ADDR_SLEEP: begin
        next_rdata = sleep_view;
      end
      `BBREG_ADDR_MODE: begin
        next_rdata = mode_view;
      end
      `BBREG_ADDR_CONFIG: begin
        next_rdata = config_view;
      end
      default: begin
        next_rdata = `BBREG_ZERO8;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // operating point
  reg  [6:0] next_code;
  reg        next_on;
  reg        next_pfm;
  reg        next_reserved;

  // sleep outranks standby when both are raised
  always @* begin
    next_code = {range_sel, buck_b_normal_code};
    next_on   = `BBREG_BIT_SET;
    next_pfm  = `BBREG_BIT_CLR;
    if (i_sleep) begin
      next_code = {range_sel, sleep_code};
      next_on   = buck_b_sleep_state;
      next_pfm  = buck_b_sleep_state;
    end else if (i_standby) begin
      next_code = {range_sel, standby_code};
    end
  end

  // flagged, not clamped: the analog side decides how to treat it
  always @* begin
    next_reserved = (next_code >= `BBREG_RESERVED_MIN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  // read data falls back to zero when no read was made
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_reg_rdata <= `BBREG_ZERO8;
      o_reg_hit   <= `BBREG_BIT_CLR;
    end else begin
      o_reg_rdata <= i_reg_rd ? next_rdata : `BBREG_ZERO8;
      o_reg_hit   <= (i_reg_rd | i_reg_wr) & next_hit;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_active_code   <= `BBREG_CODE7_RST;
      o_code_reserved <= `BBREG_BIT_CLR;
    end else begin
      o_active_code   <= next_code;
      o_code_reserved <= next_reserved;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_regulator_on <= `BBREG_BIT_CLR;
      o_sleep_pfm    <= `BBREG_BIT_CLR;
    end else begin
      o_regulator_on <= next_on;
      o_sleep_pfm    <= next_pfm;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_switching_mode    <= `BBREG_MODE_RST;
      o_current_limit_sel <= `BBREG_BIT_CLR;
    end else begin
      o_switching_mode    <= buck_b_switching_mode;
      o_current_limit_sel <= buck_b_current_limit_sel;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_frequency_sel  <= `BBREG_SEL2_RST;
      o_phase_sel      <= `BBREG_SEL2_RST;
      o_slew_speed_sel <= `BBREG_SEL2_RST;
    end else begin
      o_frequency_sel  <= buck_b_frequency_sel;
      o_phase_sel      <= buck_b_phase_sel;
      o_slew_speed_sel <= buck_b_slew_speed_sel;
    end
  end

endmodule // bbreg_bank

// File: verif/bbreg_monitor.sv
// port assertions for the regulator configuration bank
`timescale 1ns/1ps
module bbreg_monitor (
  input wire       i_ref_clk, i_reset, i_reg_wr, i_reg_rd, i_sleep,
  input wire       o_reg_hit, o_code_reserved, o_regulator_on, o_sleep_pfm,
  input wire [7:0] i_reg_addr, o_reg_rdata,
  input wire [6:0] o_active_code,
  input wire [3:0] o_switching_mode
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  wire acc = i_reg_wr | i_reg_rd;
  wire inmap = i_reg_addr >= 8'h35 && i_reg_addr <= 8'h39;
  wire rd38 = i_reg_rd && i_reg_addr == 8'h38;
  a_hit_map: assert property (acc && inmap |=> o_reg_hit)
    else $error("no hit");
  a_miss_zero: assert property (acc && !inmap |=> !o_reg_hit && o_reg_rdata == 8'h00)
    else $error("miss answered");
  a_idle_zero: assert property (!i_reg_rd |=> o_reg_rdata == 8'h00)
    else $error("rdata not idle");
  a_mode_unused: assert property (rd38 |=> (o_reg_rdata & 8'hd0) == 8'h00)
    else $error("unused bits set");
  a_mode_copy: assert property (rd38 && !i_reg_wr |=> o_reg_rdata[3:0] == o_switching_mode)
    else $error("mode mismatch");
  a_awake_on: assert property (!i_sleep && !$past(i_reset) |=> o_regulator_on)
    else $error("off while awake");
  a_pfm_sleep: assert property (o_sleep_pfm |-> o_regulator_on && $past(i_sleep))
    else $error("pfm outside sleep");
  a_code_flag: assert property ($stable(o_active_code) |-> o_code_reserved == (o_active_code >= 7'h73))
    else $error("reserved flag wrong");
  c_hit: cover property (o_reg_hit);
  c_pfm: cover property (o_sleep_pfm);
  c_res: cover property (o_code_reserved);
endmodule // bbreg_monitor
bind bbreg_bank bbreg_monitor u_mon (.*);

// File: verif/bbreg_host.sv
// host model making one-byte register accesses
`timescale 1ns/1ps
module bbreg_host (
  input  wire       i_ref_clk,
  output reg  [7:0] o_addr = 8'h00,
  output reg  [7:0] o_wdata = 8'h00,
  output reg        o_wr = 1'b0,
  output reg        o_rd = 1'b0
);
  // idle bus shows inverted values so stale data cannot pass as valid
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
    @(negedge i_ref_clk);
    {o_wr, o_rd, o_addr, o_wdata} = {2'b00, ~o_addr, ~o_wdata};
  endtask
endmodule // bbreg_host

// File: verif/test_bbreg_bank.sv
// self-checking bench for the regulator configuration bank
`timescale 1ns/1ps
module test_bbreg_bank;
  reg        i_ref_clk = 1'b0, i_reset = 1'b1, i_range_cfg = 1'b1, i_range_load = 1'b1;
  reg        i_standby = 1'b0, i_sleep = 1'b0;
  reg  [7:0] i;
  wire [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  wire       i_reg_wr, i_reg_rd, o_reg_hit, o_code_reserved, o_regulator_on, o_sleep_pfm;
  wire       o_current_limit_sel;
  wire [6:0] o_active_code;
  wire [3:0] o_switching_mode;
  wire [1:0] o_frequency_sel, o_phase_sel, o_slew_speed_sel;
  integer    failures = 0, checked = 0;
  bbreg_host host (.i_ref_clk, .o_addr(i_reg_addr), .o_wdata(i_reg_wdata), .o_wr(i_reg_wr),
    .o_rd(i_reg_rd));
  bbreg_bank DUT (.*);
  initial forever #20 i_ref_clk = ~i_ref_clk;
  task chk(input [7:0] got, input [7:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task rd_chk(input [7:0] a, input [7:0] exp);
    host.acc(1'b0, a, 8'h00);
    chk(o_reg_rdata, exp);
    chk({7'h00, o_reg_hit}, {7'h00, a >= 8'h35 && a <= 8'h39});
  endtask
  task print_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #20000;
    failures = failures + 1;
    print_verdict;
  end
  initial begin
    repeat (8) @(negedge i_ref_clk);
    i_reset = 1'b0;
    @(negedge i_ref_clk);
    i_range_load = 1'b0;
    for (i = 0; i < 5; i = i + 1) rd_chk(8'h35 + i, i < 3 ? 8'h40 : 8'h00);
    $display("reset values done");
    for (i = 0; i < 5; i = i + 1) host.acc(1'b1, 8'h35 + i, 8'hff);
    for (i = 0; i < 5; i = i + 1) rd_chk(8'h35 + i, i < 3 ? 8'h7f : i < 4 ? 8'h2f : 8'hff);
    host.acc(1'b1, 8'h34, 8'hff);
    rd_chk(8'h34, 8'h00);
    rd_chk(8'h3a, 8'h00);
    $display("access done");
    chk({o_code_reserved, o_active_code}, 8'hff);
    chk({o_slew_speed_sel, o_phase_sel, o_frequency_sel, 1'b1, o_current_limit_sel}, 8'hff);
    chk({4'h0, o_switching_mode}, 8'h0f);
    host.acc(1'b1, 8'h36, 8'h05);
    host.acc(1'b1, 8'h37, 8'h33);
    i_standby = 1'b1;
    @(negedge i_ref_clk);
    chk({o_code_reserved, o_active_code}, 8'h45);
    i_sleep = 1'b1;
    @(negedge i_ref_clk);
    chk({o_code_reserved, o_active_code}, 8'hf3);
    chk({6'h00, o_regulator_on, o_sleep_pfm}, 8'h03);
    host.acc(1'b1, 8'h38, 8'h00);
    @(negedge i_ref_clk);
    chk({6'h00, o_regulator_on, o_sleep_pfm}, 8'h00);
    $display("mode outputs done");
    i_range_cfg = 1'b0;
    i_range_load = 1'b1;
    @(negedge i_ref_clk);
    i_range_load = 1'b0;
    host.acc(1'b1, 8'h35, 8'hff);
    rd_chk(8'h35, 8'h3f);
    rd_chk(8'h37, 8'h33);
    $display("range bit done");
    print_verdict;
  end
endmodule // test_bbreg_bank
